// ==== design/solr_pkg.sv ====
// constants, codes and carriers shared by the output/lock-detect register bank
// assumes one 10 MHz system clock; serial pins already synchronous to it
package solr_pkg;

   localparam int unsigned WORD_W         = 32;
   localparam int unsigned IDX_W          = 3;
   localparam logic [2:0]  IDX_OUTPUT     = 3'h4;
   localparam logic [2:0]  IDX_LOCKMODE   = 3'h5;
   localparam logic [2:0]  IDX_STATUS     = 3'h6;
   localparam logic [31:0] LOCKMODE_RESET = 32'h00400005;

   // output configuration word fields
   localparam int unsigned SECOND_PWR_HI  = 7;
   localparam int unsigned SECOND_PWR_LO  = 6;
   localparam int unsigned FIRST_EN_BIT   = 5;
   localparam int unsigned FIRST_PWR_HI   = 4;
   localparam int unsigned FIRST_PWR_LO   = 3;

   // lock-detect and mode word fields
   localparam int unsigned AUTO_INT_BIT   = 24;
   localparam int unsigned LOCK_FN_HI     = 23;
   localparam int unsigned LOCK_FN_LO     = 22;
   localparam int unsigned MUX_MSB_BIT    = 18;

   // lock pin functions
   localparam logic [1:0]  LOCK_FN_LOW     = 2'h0;
   localparam logic [1:0]  LOCK_FN_DIGITAL = 2'h1;
   localparam logic [1:0]  LOCK_FN_ANALOG  = 2'h2;
   localparam logic [1:0]  LOCK_FN_HIGH    = 2'h3;

   // power codes: 0 = -4 dBm, 1 = -1 dBm, 2 = +2 dBm, 3 = +5 dBm
   localparam logic [1:0]  PWR_MINUS4     = 2'h0;

   // mux select code that routes the status readback to the mux pin
   localparam logic [3:0]  MUX_READBACK   = 4'hc;

   localparam logic [7:0]  STATUS_RSVD_HI = 8'h00;
   localparam logic [10:0] STATUS_RSVD_MID = 11'h000;
   localparam logic [11:0] FRAC_ZERO      = 12'h000;

   // status inputs travelling together
   typedef struct packed {
      logic [2:0] tuneAdc;
      logic [5:0] activeCore;
   } solr_status_s;

   // one received configuration word
   typedef struct packed {
      logic        valid;
      logic [31:0] data;
   } solr_word_s;

endpackage

// ==== design/solr_regs.sv ====
// output configuration, lock-detect/mode and status registers of the synthesizer
// assumes the host drives the serial pins synchronously and keeps reserved bits zero
// How it works
// - word index bits 2:0 pick register
// - bits 7:6 set second output power
// - bit 5 enables first output
// - bits 4:3 set first output power
// - lock/mode register resets to 00400005
// - auto bit and zero fraction: integer mode
// - auto bit clear keeps fractional mode
// - bits 23:22 choose lock pin source
// - bit 18 is mux select msb
// - status register ignores write data
// - por bit set until status read
// - status 22:20 give tuning voltage adc
// - status 8:3 give active core index
// - status read serially via mux pin
`timescale 1ns/10ps
`default_nettype none
module solr_regs
(
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   input  wire logic                   serClk,
   input  wire logic                   serData,
   input  wire logic                   serLatch,
   input  wire logic [2:0]             muxSelectLow,
   input  wire logic [11:0]            fracValue,
   input  wire logic                   digitalLock,
   input  wire logic                   analogLock,
   input  wire logic                   secondOutputEnable,
   input  wire solr_pkg::solr_status_s statusIn,
   output var  logic                   lockPin,
   output var  logic                   integerMode,
   output var  logic                   firstRfOutput,
   output var  logic [1:0]             firstOutputPower,
   output var  logic                   secondRfOutput,
   output var  logic [1:0]             secondOutputPower,
   output var  logic [3:0]             muxSelect,
   output var  logic                   multiplexedOutputPin
);
   import solr_pkg::*;

   typedef struct packed {
      // stored configuration fields
      logic [1:0]        secondPwrCfg;
      logic              firstEnCfg;
      logic [1:0]        firstPwrCfg;
      logic [WORD_W-1:0] lockMode;
      // status readback
      logic              porPending;
      logic [WORD_W-1:0] readShift;
      // registered pin levels
      logic              lockPin;
      logic              integerMode;
      logic              firstRf;
      logic [1:0]        firstPwr;
      logic              secondRf;
      logic [1:0]        secondPwr;
      logic [3:0]        muxSel;
      logic              muxPin;
   } solr_state_s;

   // register copy, its next value and the combinational helpers
   solr_state_s        state_q;
   solr_state_s        state_d;
   logic               clkRise;
   solr_word_s         word;
   logic [WORD_W-1:0]  statusWord;
   logic [3:0]         muxSelNext;

   // serial front end: pin edges and word assembly
   solr_serial_rx u_rx
   (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .serClk     (serClk),
      .serData    (serData),
      .serLatch   (serLatch),
      .serClkRise (clkRise),
      .wordOut    (word)
   );

   // status image; the index field reads back as the register's own index
   // built from the flag's current value, so the first load still shows it set
   assign statusWord = {STATUS_RSVD_HI,                                             // reserved top byte
                        state_q.porPending,
                        statusIn.tuneAdc,
                        STATUS_RSVD_MID,                                            // reserved middle bits
                        statusIn.activeCore,
                        IDX_STATUS};

   // register writes, readback shifting and the derived pin levels
   always_comb
   begin
      state_d    = state_q;
      // select as it stands before this word lands
      muxSelNext = {state_q.lockMode[MUX_MSB_BIT], muxSelectLow};
      // a committed word takes priority; a serial rise in that cycle is not shifted
      if (word.valid)
      begin
         unique case (word.data[IDX_W-1:0])
            IDX_OUTPUT:
            begin
               // only the low fields of this word live in this bank
               state_d.secondPwrCfg = word.data[SECOND_PWR_HI:SECOND_PWR_LO];
               state_d.firstEnCfg   = word.data[FIRST_EN_BIT];
               state_d.firstPwrCfg  = word.data[FIRST_PWR_HI:FIRST_PWR_LO];
            end
            IDX_LOCKMODE:
            begin
               // reserved bits are stored as sent; the host keeps them zero
               // nothing checks them here, so a stray one is simply kept
               state_d.lockMode = word.data;
            end
            IDX_STATUS:
            begin
               // a status write's data never alters status; in readback mode it starts a read and clears the por flag
               if (muxSelNext == MUX_READBACK)
               begin
                  state_d.readShift  = statusWord;
                  state_d.porPending = 1'b0;
               end
            end
            default:
            begin
               // indices 0 to 3 and 7 belong to other banks
               state_d.readShift = state_q.readShift;
            end
         endcase
      end
      else if (clkRise)
      begin
         // each serial clock rise presents the next status bit, msb first
         // zeros fill from below, so reading past 32 bits returns zeros
         state_d.readShift = {state_q.readShift[WORD_W-2:0], 1'b0};
      end

      // stored msb over the low select bits held in another bank
      state_d.muxSel = {state_d.lockMode[MUX_MSB_BIT], muxSelectLow};
      // outside readback mode the pin rests low instead of showing stale bits
      state_d.muxPin = (state_d.muxSel == MUX_READBACK) ? state_d.readShift[WORD_W-1] : 1'b0;

      // lock inputs are taken as they stand each cycle
      unique case (state_d.lockMode[LOCK_FN_HI:LOCK_FN_LO])
         LOCK_FN_LOW:
         begin
            // pin parked low
            state_d.lockPin = 1'b0;
         end
         LOCK_FN_DIGITAL:
         begin
            // digital indication, one cycle behind its input
            state_d.lockPin = digitalLock;
         end
         LOCK_FN_ANALOG:
         begin
            // analog indication passed through as a level
            state_d.lockPin = analogLock;
         end
         LOCK_FN_HIGH:
         begin
            // pin parked high
            state_d.lockPin = 1'b1;
         end
      endcase

      // integer mode only with the auto bit set and a zero fraction
      // the fraction lives in another bank and is followed one cycle late
      state_d.integerMode = state_d.lockMode[AUTO_INT_BIT] && (fracValue == FRAC_ZERO);

      // a disabled output carries no signal and reports the lowest code
      state_d.firstRf   = state_d.firstEnCfg;
      if (state_d.firstEnCfg)
      begin
         state_d.firstPwr = state_d.firstPwrCfg;
      end
      else
      begin
         // the stored code is kept, though re-enabling rewrites it from bits 4:3 of the same word
         state_d.firstPwr = PWR_MINUS4;
      end
      // the second enable comes from the upper field outside this bank
      state_d.secondRf  = secondOutputEnable;
      if (secondOutputEnable)
      begin
         state_d.secondPwr = state_d.secondPwrCfg;
      end
      else
      begin
         state_d.secondPwr = PWR_MINUS4;
      end
   end

   // por flag and lock/mode default are constants under reset
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         // output configuration has no set default; zero keeps the first output off
         // readback shift starts empty, so the mux pin rests low
         state_q            <= '0;
         state_q.lockMode   <= LOCKMODE_RESET;
         state_q.porPending <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // every output straight from its flip-flop
   assign lockPin              = state_q.lockPin;
   assign integerMode          = state_q.integerMode;
   assign firstRfOutput        = state_q.firstRf;
   assign firstOutputPower     = state_q.firstPwr;
   assign secondRfOutput       = state_q.secondRf;
   assign secondOutputPower    = state_q.secondPwr;
   assign muxSelect            = state_q.muxSel;
   assign multiplexedOutputPin = state_q.muxPin;

endmodule
`default_nettype wire

// ==== design/solr_serial_rx.sv ====
// serial word receiver: shifts data in msb first on clock rises, hands a word over on latch rise
// assumes all three pins are synchronous to clk_sys and slower than it
`timescale 1ns/10ps
`default_nettype none
module solr_serial_rx
(
   input  wire logic               clk_sys,
   input  wire logic               rst,
   input  wire logic               serClk,
   input  wire logic               serData,
   input  wire logic               serLatch,
   output var  logic               serClkRise,
   output var  solr_pkg::solr_word_s wordOut
);
   import solr_pkg::*;

   typedef struct packed {
      logic               clkPrev;
      logic               latchPrev;
      logic [WORD_W-1:0]  shift;
      logic               clkRise;
      solr_word_s         word;
   } solr_rx_s;

   solr_rx_s state_q;
   solr_rx_s state_d;

   // edge detection on the sampled pins; bits shift only while latch is low
   always_comb
   begin
      state_d            = state_q;
      state_d.clkPrev    = serClk;
      state_d.latchPrev  = serLatch;
      state_d.clkRise    = serClk & ~state_q.clkPrev;
      state_d.word.valid = 1'b0;
      if (serClk && !state_q.clkPrev && !serLatch)
      begin
         state_d.shift = {state_q.shift[WORD_W-2:0], serData};
      end
      // latch rise commits the word, even a short one: stale bits fill the top
      if (serLatch && !state_q.latchPrev)
      begin
         state_d.word.valid = 1'b1;
         state_d.word.data  = state_q.shift;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign serClkRise = state_q.clkRise;
   assign wordOut    = state_q.word;

endmodule
`default_nettype wire

// ==== verif/solr_host_model.sv ====
// host side of the serial port: shifts words in, reads status back
// assumes the bench calls its tasks from one process
`timescale 1ns/10ps
`default_nettype none
module solr_host_model
(
   input  wire logic clk_sys,
   input  wire logic muxPin,
   output var  logic serClk,
   output var  logic serData,
   output var  logic serLatch
);
   initial {serClk, serData, serLatch} = 3'h0;
   // wait edges, then move just after the last one
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // msb first; clock parked low between frames
   task automatic write_word(input logic [31:0] w);
      for (int i = 31; i >= 0; i--)
      begin
         serData = w[i];
         tick(2);
         serClk = 1'b1;
         tick(2);
         serClk = 1'b0;
      end
      serData = ~w[0]; // no stale bit left on the line
      tick(2);
      serLatch = 1'b1;
      tick(2);
      serLatch = 1'b0;
      tick(4);
   endtask
   // one status bit per clock rise, sampled late so the shift has landed
   task automatic read_word(output logic [31:0] w);
      w[31] = muxPin;
      for (int i = 30; i >= 0; i--)
      begin
         serClk = 1'b1;
         tick(4);
         w[i] = muxPin;
         serClk = 1'b0;
         tick(2);
      end
   endtask
endmodule
`default_nettype wire

// ==== verif/solr_regs_properties.sv ====
// port assertions for the register bank
// assumes a bind into solr_regs, single clock domain
`timescale 1ns/10ps
`default_nettype none
module solr_regs_properties
   import solr_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        serLatch,
   input wire logic [2:0]  muxSelectLow,
   input wire logic [11:0] fracValue,
   input wire logic        digitalLock,
   input wire logic        lockPin,
   input wire logic        integerMode,
   input wire logic        firstRfOutput,
   input wire logic [1:0]  firstOutputPower,
   input wire logic        secondRfOutput,
   input wire logic [1:0]  secondOutputPower,
   input wire logic [3:0]  muxSelect,
   input wire logic        multiplexedOutputPin
);
   logic [3:0] sinceLatch;
   logic [1:0] upCnt;
   logic       prevLatch;
   logic       wrSeen;
   // age of the last latch rise; upCnt hides the lag right after reset
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
         {sinceLatch, upCnt, prevLatch, wrSeen} <= {4'hf, 2'h0, 2'h0};
      else
      begin
         prevLatch  <= serLatch;
         upCnt      <= (upCnt == 2'h3) ? upCnt : upCnt + 2'h1;
         wrSeen     <= wrSeen | (serLatch & ~prevLatch);
         sinceLatch <= (serLatch & ~prevLatch) ? 4'h0 : sinceLatch + {3'h0, sinceLatch != 4'hf};
      end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_first_off; !firstRfOutput |-> firstOutputPower == PWR_MINUS4; endproperty
   a_first_off: assert property (p_first_off) else $error("first power while off");
   property p_second_off; !secondRfOutput |-> secondOutputPower == PWR_MINUS4; endproperty
   a_second_off: assert property (p_second_off) else $error("second power while off");
   property p_mux_low; upCnt == 2'h3 |-> muxSelect[2:0] == $past(muxSelectLow); endproperty
   a_mux_low: assert property (p_mux_low) else $error("mux low bits");
   property p_int_frac; upCnt == 2'h3 && integerMode |-> $past(fracValue) == FRAC_ZERO; endproperty
   a_int_frac: assert property (p_int_frac) else $error("integer mode with fraction");
   property p_pin_quiet; (muxSelect != MUX_READBACK) [*2] |-> !multiplexedOutputPin; endproperty
   a_pin_quiet: assert property (p_pin_quiet) else $error("mux pin active");
   property p_dflt; upCnt == 2'h3 && !wrSeen |-> lockPin == $past(digitalLock) && !integerMode && !muxSelect[3];
   endproperty
   a_dflt: assert property (p_dflt) else $error("reset lock/mode value");
   property p_msb_cause; $changed(muxSelect[3]) |-> sinceLatch < 4'h8; endproperty
   a_msb_cause: assert property (p_msb_cause) else $error("mux msb moved alone");
   property p_first_cause; $changed({firstRfOutput, firstOutputPower}) |-> sinceLatch < 4'h8; endproperty
   a_first_cause: assert property (p_first_cause) else $error("first output moved alone");
endmodule
bind solr_regs solr_regs_properties i_props (.clk_sys(clk_sys), .rst(rst), .serLatch(serLatch),
   .muxSelectLow(muxSelectLow), .fracValue(fracValue), .digitalLock(digitalLock), .lockPin(lockPin),
   .integerMode(integerMode), .firstRfOutput(firstRfOutput), .firstOutputPower(firstOutputPower),
   .secondRfOutput(secondRfOutput), .secondOutputPower(secondOutputPower), .muxSelect(muxSelect),
   .multiplexedOutputPin(multiplexedOutputPin));
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench for the register bank
// assumes the host model drives the serial pins
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import solr_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, serClk, serData, serLatch, lockPin, integerMode, firstRfOutput;
   logic secondRfOutput, multiplexedOutputPin, digitalLock, analogLock, secondOutputEnable;
   logic [1:0] firstOutputPower, secondOutputPower;
   logic [2:0] muxSelectLow;
   logic [3:0] muxSelect;
   logic [11:0] fracValue;
   logic [31:0] w, r;
   solr_status_s statusIn;
   int miscompares = 0, nCompared = 0;
   always #50 clk_sys = ~clk_sys;
   solr_regs i_dut (.clk_sys(clk_sys), .rst(rst), .serClk(serClk), .serData(serData), .serLatch(serLatch),
      .muxSelectLow(muxSelectLow), .fracValue(fracValue), .digitalLock(digitalLock), .analogLock(analogLock),
      .secondOutputEnable(secondOutputEnable), .statusIn(statusIn), .lockPin(lockPin), .integerMode(integerMode),
      .firstRfOutput(firstRfOutput), .firstOutputPower(firstOutputPower), .secondRfOutput(secondRfOutput),
      .secondOutputPower(secondOutputPower), .muxSelect(muxSelect), .multiplexedOutputPin(multiplexedOutputPin));
   solr_host_model i_host (.clk_sys(clk_sys), .muxPin(multiplexedOutputPin), .serClk(serClk),
      .serData(serData), .serLatch(serLatch));
   function automatic logic lock_exp(input logic [1:0] fn, input logic d, input logic a);
      return fn[1] ? (fn[0] | a) : (fn[0] & d);
   endfunction
   function automatic logic [31:0] status_word(input logic por, input solr_status_s s);
      return {STATUS_RSVD_HI, por, s.tuneAdc, STATUS_RSVD_MID, s.activeCore, IDX_STATUS};
   endfunction
   task automatic chk(input logic [31:0] e, input logic [31:0] a);
      nCompared++;
      if (e !== a)
      begin
         miscompares++;
         $display("Error at %0t: expected %h got %h", $time, e, a);
      end
   endtask
   task automatic complete_run;
      $display("compared %0d mismatches %0d", nCompared, miscompares);
      if (miscompares == 0 && nCompared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // hang guard, well beyond the few thousand cycles the tests need
   initial
   begin
      #(100 * 20000);
      miscompares++;
      complete_run();
   end
   initial
   begin
      {muxSelectLow, fracValue, digitalLock, analogLock, secondOutputEnable, statusIn} = '0;
      void'($urandom(9));
      repeat (16) @(posedge clk_sys);
      #1 rst = 1'b0;
      digitalLock = 1'b1;
      i_host.tick(4);
      chk(32'h1, lockPin);
      chk(32'h0, integerMode);
      $display("test defaults done");
      // every lock function, auto integer on and off, zero and nonzero fraction
      for (int i = 0; i < 8; i++)
      begin
         fracValue = (i % 3 == 0) ? FRAC_ZERO : 12'($urandom_range(4095, 1));
         i_host.write_word({7'h0, i[2], i[1:0], 3'h0, 1'b0, 15'h0, IDX_LOCKMODE});
         {digitalLock, analogLock} = 2'($urandom);
         i_host.tick(3);
         chk(lock_exp(i[1:0], digitalLock, analogLock), lockPin);
         chk(i[2] && fracValue == FRAC_ZERO, integerMode);
      end
      $display("test lock modes done");
      // every power code with its output on and off
      for (int i = 0; i < 8; i++)
      begin
         secondOutputEnable = i[2];
         w = {24'h0, i[1:0], ~i[2], i[1:0], IDX_OUTPUT};
         i_host.write_word(w);
         chk(w[5], firstRfOutput);
         chk(w[5] ? w[4:3] : 2'h0, firstOutputPower);
         chk(i[2] ? w[7:6] : 2'h0, secondOutputPower);
         chk(i[2], secondRfOutput);
      end
      $display("test outputs done");
      // words for other indices leave this bank alone
      for (int k = 0; k < 8; k++)
         if (k < 4 || k == 7)
         begin
            w = $urandom;
            w[2:0] = k[2:0];
            i_host.write_word(w);
            chk(6'h06, {firstRfOutput, firstOutputPower, secondOutputPower, muxSelect[3]});
            chk(32'h1, lockPin);
         end
      $display("test ignored indices done");
      // readback mode, then two status loads: flag set once, random write data ignored
      muxSelectLow = 3'h4;
      statusIn = solr_status_s'(9'($urandom));
      i_host.write_word({7'h0, 1'b0, LOCK_FN_DIGITAL, 3'h0, 1'b1, 15'h0, IDX_LOCKMODE});
      chk(MUX_READBACK, muxSelect);
      for (int k = 1; k >= 0; k--)
      begin
         w = $urandom;
         w[2:0] = IDX_STATUS;
         i_host.write_word(w);
         i_host.read_word(r);
         chk(status_word(k[0], statusIn), r);
      end
      $display("test readback done");
      // mid-run reset: defaults and the por flag come back
      rst = 1'b1;
      i_host.tick(2);
      rst = 1'b0;
      digitalLock = 1'b1;
      i_host.tick(4);
      chk(32'h1, lockPin);
      chk(32'h4, muxSelect);
      i_host.write_word({7'h0, 1'b0, LOCK_FN_DIGITAL, 3'h0, 1'b1, 15'h0, IDX_LOCKMODE});
      w = $urandom;
      w[2:0] = IDX_STATUS;
      i_host.write_word(w);
      i_host.read_word(r);
      chk(status_word(1'b1, statusIn), r);
      $display("test second reset done");
      complete_run();
   end
endmodule
`default_nettype wire
